//--- rtl/acsl_pkg.sv
// Constants for the accumulator and stack load unit
// Functional notes
// - A manipulation leaves its result in the accumulator, replacing the old value.
// - 32-bit manipulations take two consecutive words or an eight-digit constant.
// - First load in a scan only writes; later loads push the accumulator first.
// - A store after a load cancels the push of the next load.
// - Every push moves all stack entries down one level before the new top.
// - The stack holds eight levels of 32 bits.
// - A push with the eighth level occupied discards that value for good.
// - A pull drops the accumulator, moves the top into it, shifts entries up.
// - A pointer operand is a hex word address; the operand is fetched from there.
// - Word load puts a word or constant in bits 15:0 and clears bits 31:16.
// - Any load that puts zero in the accumulator sets the load-zero flag.
// - Double-word load fills all 32 bits from two words or a constant.
// - Bit-field load copies 1 to 32 consecutive bits from a bit address.
// - Bit-field load clears every accumulator bit above the count.
// - Address-conversion load turns an octal operand into its 16-bit binary value.
// - Indexed word load reads source address plus stack top into bits 15:0.
// - Indexed constant load picks a constant in a labelled area by the stack top.
// - The 32-bit accumulator is cleared at the end of every scan.
// - A word store copies accumulator bits 15:0 to the addressed word.
package acsl_pkg;
  // ----------------------------------------
  // Widths and sizes
  // ----------------------------------------
  localparam int ACSL_ACC_W = 32;
  localparam int ACSL_WORD_W = 16;
  localparam int ACSL_DEPTH = 8;
  localparam int ACSL_LVL_W = 4;
  localparam int ACSL_CNT_W = 6;
  localparam int ACSL_OCT_DIGITS = 6;
  localparam logic [5:0] ACSL_BITS_MIN = 6'h01;
  localparam logic [5:0] ACSL_BITS_MAX = 6'h20;
  localparam logic [31:0] ACSL_ACC_RST = 32'h0000_0000;
  localparam logic [15:0] ACSL_ADDR_STEP = 16'h0001;
  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [3:0] ACSL_OP_LOAD_WORD = 4'h0;
  localparam logic [3:0] ACSL_OP_LOAD_DOUBLE_WORD = 4'h1;
  localparam logic [3:0] ACSL_OP_LOAD_BIT_FIELD = 4'h2;
  localparam logic [3:0] ACSL_OP_LOAD_ADDRESS_CONVERSION = 4'h3;
  localparam logic [3:0] ACSL_OP_LOAD_INDEXED_WORD = 4'h4;
  localparam logic [3:0] ACSL_OP_LOAD_INDEXED_CONSTANT = 4'h5;
  localparam logic [3:0] ACSL_OP_STORE_WORD = 4'h6;
  localparam logic [3:0] ACSL_OP_PULL = 4'h7;
  localparam logic [3:0] ACSL_OP_AND_DOUBLE = 4'h8;
  localparam logic [3:0] ACSL_OP_SHIFT_RIGHT = 4'h9;
  // ----------------------------------------
  // Memory spaces
  // ----------------------------------------
  localparam logic ACSL_SPACE_DATA = 1'b0;
  localparam logic ACSL_SPACE_CONST = 1'b1;
endpackage

//--- rtl/acsl_stack.sv
// Push-down accumulator stack held in flip-flops
module acsl_stack
  import acsl_pkg::*;
#(
  parameter int DEPTH = ACSL_DEPTH,
  parameter int WIDTH = ACSL_ACC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pull,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] top,
  output logic [ACSL_LVL_W-1:0] levels
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [WIDTH-1:0] entry_q [DEPTH];
  logic [ACSL_LVL_W-1:0] lvl_q;
  logic full;

  assign full = (lvl_q == ACSL_LVL_W'(DEPTH));
  assign top = entry_q[0];
  assign levels = lvl_q;

  // Whole stack moves in one edge, so no half-shifted state is visible
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry_q[i] <= '0;
      end
      lvl_q <= '0;
    end else if (push) begin
      entry_q[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        entry_q[i] <= entry_q[i-1];
      end
      if (!full) begin
        lvl_q <= lvl_q + ACSL_LVL_W'(1);
      end
    end else if (pull) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        entry_q[i] <= entry_q[i+1];
      end
      entry_q[DEPTH-1] <= '0;
      if (lvl_q != '0) begin
        lvl_q <= lvl_q - ACSL_LVL_W'(1);
      end
    end
  end

  AST_PUSH_SHIFTS: assert property (@(posedge clk) disable iff (!rst_n)
    push |=> (entry_q[1] == $past(entry_q[0])) && (entry_q[0] == $past(din)))
    else $error("push did not shift stack down");
  AST_FULL_DISCARD: assert property (@(posedge clk) disable iff (!rst_n)
    (push && full) |=> (lvl_q == ACSL_LVL_W'(DEPTH)) &&
      (entry_q[DEPTH-1] == $past(entry_q[DEPTH-2])))
    else $error("full stack level count changed on push");
endmodule

//--- rtl/acsl_unit.sv
// Accumulator, stack and load sequencer of the controller CPU
module acsl_unit
  import acsl_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  input wire logic [3:0] INSTR_OP,
  input wire logic [31:0] INSTR_OPERAND,
  input wire logic INSTR_IS_CONST,
  input wire logic INSTR_IS_PTR,
  input wire logic [5:0] INSTR_COUNT,
  output logic INSTR_DONE,
  input wire logic SCAN_END,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic MEM_SPACE,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_RVALID,
  output logic BIT_RD,
  output logic [15:0] BIT_ADDR,
  input wire logic BIT_RDATA,
  input wire logic BIT_RVALID,
  output logic [31:0] ACC,
  output logic [31:0] STACK_TOP,
  output logic [3:0] STACK_LEVELS,
  output logic LOAD_ZERO_FLAG
);
  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  typedef enum logic [2:0] {
    ACSL_IDLE, ACSL_PTR, ACSL_LO, ACSL_HI, ACSL_BITS, ACSL_WR, ACSL_EXEC
  } acsl_state_t;

  function automatic logic is_load(input logic [3:0] op);
    return (op == ACSL_OP_LOAD_WORD) || (op == ACSL_OP_LOAD_DOUBLE_WORD) ||
           (op == ACSL_OP_LOAD_BIT_FIELD) || (op == ACSL_OP_LOAD_ADDRESS_CONVERSION) ||
           (op == ACSL_OP_LOAD_INDEXED_WORD) || (op == ACSL_OP_LOAD_INDEXED_CONSTANT);
  endfunction

  // Octal digits arrive one per nibble; the top bit of each nibble is ignored
  function automatic logic [15:0] oct_to_bin(input logic [23:0] digits);
    logic [17:0] r;
    r = '0;
    for (int i = 0; i < ACSL_OCT_DIGITS; i++) begin
      r[3*i +: 3] = digits[4*i +: 3];
    end
    return r[15:0];
  endfunction

  function automatic logic [5:0] clamp_count(input logic [5:0] c);
    if (c < ACSL_BITS_MIN) begin
      return ACSL_BITS_MIN;
    end
    if (c > ACSL_BITS_MAX) begin
      return ACSL_BITS_MAX;
    end
    return c;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  acsl_state_t state_q, state_d;
  logic [3:0] op_q;
  logic dbl_q;
  logic [15:0] addr_q, addr_d;
  logic [15:0] lo_q, hi_q;
  logic [31:0] field_q;
  logic [5:0] cnt_q, idx_q;
  logic [31:0] acc_q;
  logic push_arm_q;
  logic zero_q;
  logic space_q;
  logic done_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic accept, in_exec, exec_load, exec_pull, stk_push, stk_pull;
  logic op_dbl, op_idx, needs_ptr, bit_last;
  logic [15:0] index_val, oct_val;
  logic [31:0] stack_top, load_val, result;
  logic [3:0] stack_levels;

  assign accept = (state_q == ACSL_IDLE) && INSTR_VALID;
  assign in_exec = (state_q == ACSL_EXEC);
  assign exec_load = in_exec && is_load(op_q);
  assign exec_pull = in_exec && (op_q == ACSL_OP_PULL);
  assign stk_push = exec_load && push_arm_q;
  assign stk_pull = exec_pull;
  assign op_dbl = (INSTR_OP == ACSL_OP_LOAD_DOUBLE_WORD) || (INSTR_OP == ACSL_OP_AND_DOUBLE);
  assign op_idx = (INSTR_OP == ACSL_OP_LOAD_INDEXED_WORD) ||
                  (INSTR_OP == ACSL_OP_LOAD_INDEXED_CONSTANT);
  assign needs_ptr = INSTR_IS_PTR && !op_idx;
  // Offset sits in the accumulator until this load's own push moves it to the top
  assign index_val = push_arm_q ? acc_q[15:0] : stack_top[15:0];
  assign oct_val = oct_to_bin(INSTR_OPERAND[23:0]);
  assign bit_last = (idx_q == cnt_q - 6'h01);

  assign load_val = (op_q == ACSL_OP_LOAD_BIT_FIELD) ? field_q :
                    (op_q == ACSL_OP_LOAD_DOUBLE_WORD) ? {hi_q, lo_q} :
                    {16'h0000, lo_q};

  assign result = (op_q == ACSL_OP_AND_DOUBLE) ? (acc_q & {hi_q, lo_q}) :
                  (op_q == ACSL_OP_SHIFT_RIGHT) ? (acc_q >> cnt_q) :
                  (op_q == ACSL_OP_PULL) ? stack_top : load_val;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    unique case (state_q)
      ACSL_IDLE: begin
        if (INSTR_VALID) begin
          addr_d = op_idx ? (INSTR_OPERAND[15:0] + index_val) : INSTR_OPERAND[15:0];
          if (INSTR_OP == ACSL_OP_STORE_WORD) begin
            state_d = needs_ptr ? ACSL_PTR : ACSL_WR;
          end else if (INSTR_OP == ACSL_OP_LOAD_BIT_FIELD) begin
            state_d = ACSL_BITS;
          end else if (op_idx) begin
            state_d = ACSL_LO;
          end else if (INSTR_IS_CONST || (INSTR_OP == ACSL_OP_PULL) ||
                       (INSTR_OP == ACSL_OP_SHIFT_RIGHT) ||
                       (INSTR_OP == ACSL_OP_LOAD_ADDRESS_CONVERSION)) begin
            state_d = ACSL_EXEC;
          end else begin
            state_d = needs_ptr ? ACSL_PTR : ACSL_LO;
          end
        end
      end
      ACSL_PTR: begin
        if (MEM_RVALID) begin
          addr_d = MEM_RDATA;
          state_d = (op_q == ACSL_OP_STORE_WORD) ? ACSL_WR : ACSL_LO;
        end
      end
      ACSL_LO: begin
        if (MEM_RVALID) begin
          addr_d = addr_q + ACSL_ADDR_STEP;
          state_d = dbl_q ? ACSL_HI : ACSL_EXEC;
        end
      end
      ACSL_HI: begin
        if (MEM_RVALID) begin
          state_d = ACSL_EXEC;
        end
      end
      ACSL_BITS: begin
        if (BIT_RVALID) begin
          addr_d = addr_q + ACSL_ADDR_STEP;
          state_d = bit_last ? ACSL_EXEC : ACSL_BITS;
        end
      end
      ACSL_WR: state_d = ACSL_IDLE;
      ACSL_EXEC: state_d = ACSL_IDLE;
      default: state_d = ACSL_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q <= ACSL_IDLE;
      addr_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      op_q <= ACSL_OP_LOAD_WORD;
      dbl_q <= 1'b0;
      space_q <= ACSL_SPACE_DATA;
      cnt_q <= ACSL_BITS_MIN;
    end else if (accept) begin
      op_q <= INSTR_OP;
      dbl_q <= op_dbl;
      space_q <= (INSTR_OP == ACSL_OP_LOAD_INDEXED_CONSTANT) ? ACSL_SPACE_CONST
                                                              : ACSL_SPACE_DATA;
      cnt_q <= (INSTR_OP == ACSL_OP_SHIFT_RIGHT) ? INSTR_COUNT : clamp_count(INSTR_COUNT);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      lo_q <= '0;
      hi_q <= '0;
    end else if (accept) begin
      lo_q <= (INSTR_OP == ACSL_OP_LOAD_ADDRESS_CONVERSION) ? oct_val : INSTR_OPERAND[15:0];
      hi_q <= INSTR_OPERAND[31:16];
    end else if (MEM_RVALID && (state_q == ACSL_LO)) begin
      lo_q <= MEM_RDATA;
    end else if (MEM_RVALID && (state_q == ACSL_HI)) begin
      hi_q <= MEM_RDATA;
    end
  end

  // Field starts cleared so bits above the count stay zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || accept) begin
      field_q <= '0;
      idx_q <= '0;
    end else if (BIT_RVALID && (state_q == ACSL_BITS)) begin
      field_q[idx_q[4:0]] <= BIT_RDATA;
      idx_q <= idx_q + 6'h01;
    end
  end

  // ----------------------------------------
  // Accumulator and flags
  // ----------------------------------------
  // Scan end wins over a step finishing in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      acc_q <= ACSL_ACC_RST;
      push_arm_q <= 1'b0;
    end else if (SCAN_END) begin
      acc_q <= ACSL_ACC_RST;
      push_arm_q <= 1'b0;
    end else if (in_exec) begin
      acc_q <= result;
      if (is_load(op_q)) begin
        push_arm_q <= 1'b1;
      end
    end else if (state_q == ACSL_WR) begin
      push_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      zero_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= in_exec || (state_q == ACSL_WR);
      if (exec_load) begin
        zero_q <= (load_val == 32'h0000_0000);
      end
    end
  end

  acsl_stack #(
    .DEPTH(ACSL_DEPTH),
    .WIDTH(ACSL_ACC_W)
  ) acsl_stack_inst (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .push(stk_push),
    .pull(stk_pull),
    .din(acc_q),
    .top(stack_top),
    .levels(stack_levels)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign INSTR_READY = (state_q == ACSL_IDLE);
  assign INSTR_DONE = done_q;
  assign MEM_RD = (state_q == ACSL_PTR) || (state_q == ACSL_LO) || (state_q == ACSL_HI);
  assign MEM_WR = (state_q == ACSL_WR);
  assign MEM_SPACE = space_q;
  assign MEM_ADDR = addr_q;
  assign MEM_WDATA = acc_q[15:0];
  assign BIT_RD = (state_q == ACSL_BITS);
  assign BIT_ADDR = addr_q;
  assign ACC = acc_q;
  assign STACK_TOP = stack_top;
  assign STACK_LEVELS = stack_levels;
  assign LOAD_ZERO_FLAG = zero_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_WORD_UPPER_CLEAR: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_load && !SCAN_END && (op_q == ACSL_OP_LOAD_WORD))
      |=> (ACC == {16'h0000, $past(lo_q)}))
    else $error("word load did not land in low half");

  AST_SECOND_LOAD_PUSHES: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_load && push_arm_q) |=> (STACK_TOP == $past(acc_q)))
    else $error("later load did not push the accumulator");

  AST_FIRST_LOAD_NO_PUSH: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_load && !push_arm_q) |=> $stable(STACK_LEVELS) && $stable(STACK_TOP))
    else $error("first load touched the stack");

  AST_STORE_CANCELS: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    MEM_WR ##1 (INSTR_READY && INSTR_VALID && is_load(INSTR_OP) && !INSTR_IS_PTR &&
               INSTR_IS_CONST && (INSTR_OP != ACSL_OP_LOAD_BIT_FIELD) && !op_idx)
      ##1 1'b1 |=> $stable(STACK_LEVELS))
    else $error("load after a store still pushed");

  AST_ZERO_FLAG: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_load && !SCAN_END) |=> (LOAD_ZERO_FLAG == (ACC == 32'h0000_0000)))
    else $error("load-zero flag disagrees with loaded value");

  AST_DOUBLE_FULL: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_load && !SCAN_END && (op_q == ACSL_OP_LOAD_DOUBLE_WORD))
      |=> (ACC == {$past(hi_q), $past(lo_q)}))
    else $error("double load did not fill 32 bits");

  AST_FIELD_UPPER_ZERO: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_load && !SCAN_END && (op_q == ACSL_OP_LOAD_BIT_FIELD))
      |=> ((ACC >> $past(cnt_q)) == 32'h0000_0000))
    else $error("bit-field load left bits above count");

  AST_PULL_TOP: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (exec_pull && !SCAN_END) |=> (ACC == $past(stack_top)))
    else $error("pull did not move stack top into accumulator");

  AST_SCAN_CLEAR: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    SCAN_END |=> (ACC == ACSL_ACC_RST) && !push_arm_q)
    else $error("scan end did not clear accumulator");

  AST_POINTER_FOLLOW: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    ((state_q == ACSL_PTR) && MEM_RVALID) |=> (MEM_ADDR == $past(MEM_RDATA)) &&
      (MEM_RD == (op_q != ACSL_OP_STORE_WORD)) && (MEM_WR == (op_q == ACSL_OP_STORE_WORD)))
    else $error("pointer word not used as address");
endmodule

//--- sim/acsl_unit_test.sv
// Self-checking testbench for the accumulator and stack load unit
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module acsl_unit_test
  import acsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk, rst_n, instr_valid, instr_ready, instr_is_const, instr_is_ptr, instr_done;
  logic [3:0] instr_op;
  logic [31:0] instr_operand;
  logic [5:0] instr_count;
  logic scan_end, mem_rd, mem_wr, mem_space, mem_rvalid, bit_rd, bit_rdata, bit_rvalid;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, bit_addr;
  logic [31:0] acc, stack_top;
  logic [3:0] stack_levels;
  logic load_zero_flag;
  int bad_count = 0;
  int samples_checked = 0;
  int stall = 0;
  // Reference model of accumulator, stack and push arm
  logic [31:0] m_acc;
  logic [31:0] m_stk [8];
  logic [3:0] m_lvl;
  logic m_flag, m_arm;
  logic [68:0] expq [$];
  logic [31:0] wq [$];
  logic [68:0] exp_note;
  logic [31:0] exp_wr;

  acsl_unit acsl_unit_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .INSTR_VALID(instr_valid), .INSTR_READY(instr_ready),
    .INSTR_OP(instr_op), .INSTR_OPERAND(instr_operand), .INSTR_IS_CONST(instr_is_const),
    .INSTR_IS_PTR(instr_is_ptr), .INSTR_COUNT(instr_count), .INSTR_DONE(instr_done),
    .SCAN_END(scan_end), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_SPACE(mem_space),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .MEM_RVALID(mem_rvalid), .BIT_RD(bit_rd), .BIT_ADDR(bit_addr), .BIT_RDATA(bit_rdata),
    .BIT_RVALID(bit_rvalid), .ACC(acc), .STACK_TOP(stack_top),
    .STACK_LEVELS(stack_levels), .LOAD_ZERO_FLAG(load_zero_flag)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Memory contents, distinct per space
  // ----------------------------------------
  function automatic logic [15:0] mrd(input logic sp, input logic [15:0] a);
    return sp ? (a * 16'h0007 + 16'h0101) : (a ^ 16'h5a3c);
  endfunction

  function automatic logic bit_of(input logic [15:0] a);
    return ^a[3:0];
  endfunction

  // ----------------------------------------
  // Memory and bit responders
  // ----------------------------------------
  // Every fourth cycle stalls so reads see both prompt and late answers
  always @(negedge sys_clk) begin
    stall++;
    if (mem_rvalid) begin
      mem_rvalid = 1'b0;
      mem_rdata = ~mem_rdata;
    end else if (mem_rd === 1'b1 && stall[1:0] != 2'b11) begin
      mem_rvalid = 1'b1;
      mem_rdata = mrd(mem_space, mem_addr);
    end
    if (bit_rvalid) begin
      bit_rvalid = 1'b0;
      bit_rdata = ~bit_rdata;
    end else if (bit_rd === 1'b1 && stall[1:0] != 2'b10) begin
      bit_rvalid = 1'b1;
      bit_rdata = bit_of(bit_addr);
    end
  end

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(negedge sys_clk) begin
    if (rst_n && instr_done === 1'b1) begin
      exp_note = expq.pop_front();
      `CHK({acc, stack_top, stack_levels, load_zero_flag}, exp_note)
    end
    if (rst_n && mem_wr === 1'b1) begin
      exp_wr = wq.pop_front();
      `CHK({mem_addr, mem_wdata}, exp_wr)
    end
  end

  // ----------------------------------------
  // Instruction driver with model update
  // ----------------------------------------
  task automatic issue(input logic [3:0] op, input logic [31:0] opd, input logic c,
                       input logic p, input logic [5:0] n);
    logic [31:0] v;
    logic [15:0] a;
    logic [15:0] s;
    int k;
    int w;
    a = p ? mrd(1'b0, opd[15:0]) : opd[15:0];
    v = '0;
    s = '0;
    case (op)
      ACSL_OP_LOAD_WORD: v = c ? {16'h0000, opd[15:0]} : {16'h0000, mrd(1'b0, a)};
      ACSL_OP_LOAD_DOUBLE_WORD, ACSL_OP_AND_DOUBLE: begin
        v = c ? opd : {mrd(1'b0, a + 16'h0001), mrd(1'b0, a)};
      end
      ACSL_OP_LOAD_BIT_FIELD: begin
        k = (n == 6'h00) ? 1 : ((n > 6'h20) ? 32 : int'(n));
        for (int i = 0; i < k; i++) v[i] = bit_of(opd[15:0] + 16'(i));
      end
      ACSL_OP_LOAD_ADDRESS_CONVERSION: begin
        for (int i = 0; i < 6; i++) s = s + (16'(opd[4*i+:3]) << (3 * i));
        v = {16'h0000, s};
      end
      ACSL_OP_LOAD_INDEXED_WORD, ACSL_OP_LOAD_INDEXED_CONSTANT: begin
        s = m_arm ? m_acc[15:0] : m_stk[0][15:0];
        v = {16'h0000, mrd(op == ACSL_OP_LOAD_INDEXED_CONSTANT, opd[15:0] + s)};
      end
      default: v = '0;
    endcase
    if (op <= ACSL_OP_LOAD_INDEXED_CONSTANT) begin
      if (m_arm) begin
        for (int i = 7; i > 0; i--) m_stk[i] = m_stk[i-1];
        m_stk[0] = m_acc;
        if (m_lvl < 4'h8) m_lvl++;
      end
      m_acc = v;
      m_flag = (v == 32'h0000_0000);
      m_arm = 1'b1;
    end else if (op == ACSL_OP_STORE_WORD) begin
      wq.push_back({a, m_acc[15:0]});
      m_arm = 1'b0;
    end else if (op == ACSL_OP_PULL) begin
      m_acc = m_stk[0];
      for (int i = 0; i < 7; i++) m_stk[i] = m_stk[i+1];
      m_stk[7] = '0;
      if (m_lvl != 4'h0) m_lvl--;
    end else if (op == ACSL_OP_AND_DOUBLE) begin
      m_acc = m_acc & v;
    end else begin
      m_acc = m_acc >> n;
    end
    expq.push_back({m_acc, m_stk[0], m_lvl, m_flag});
    w = 0;
    while (instr_ready !== 1'b1 && w < 100) begin
      @(negedge sys_clk);
      w++;
    end
    instr_valid = 1'b1;
    instr_op = op;
    instr_operand = opd;
    instr_is_const = c;
    instr_is_ptr = p;
    instr_count = n;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    w = 0;
    while (instr_done !== 1'b1 && w < 300) begin
      @(negedge sys_clk);
      w++;
    end
    if (w >= 300) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask

  // Scan end wipes the accumulator and the push arm, never the stack
  task automatic end_scan();
    scan_end = 1'b1;
    @(negedge sys_clk);
    scan_end = 1'b0;
    m_acc = '0;
    m_arm = 1'b0;
    `CHK(acc, 32'h0000_0000)
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Generous margin over the several hundred cycles the tests need
  initial begin
    #(20000 * 4);
    bad_count++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [3:0] op;
    {instr_valid, instr_op, instr_operand, instr_is_const, instr_is_ptr} = '0;
    {instr_count, scan_end, mem_rdata, mem_rvalid, bit_rdata, bit_rvalid} = '0;
    m_acc = '0;
    m_lvl = '0;
    m_flag = 1'b0;
    m_arm = 1'b0;
    for (int i = 0; i < 8; i++) m_stk[i] = '0;
    void'($urandom(32'h4381));
    rst_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK({acc, stack_levels, load_zero_flag, instr_ready}, {32'h0, 4'h0, 2'b01})
    $display("Test reset finished");
    issue(ACSL_OP_LOAD_WORD, 32'h0001_1234, 1'b1, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_WORD, 32'hffff_0000, 1'b1, 1'b0, 6'h00);
    issue(ACSL_OP_STORE_WORD, 32'h0000_0200, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_WORD, 32'h0000_00ab, 1'b1, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_DOUBLE_WORD, 32'h0000_0000, 1'b1, 1'b0, 6'h00);
    $display("Test push and store finished");
    for (int j = 0; j < 32; j++) begin
      r = $urandom;
      op = 4'(j % 4);
      issue(op, r, (op < 4'h2) && r[20], (op < 4'h2) && !r[20] && r[21],
            (j == 2) ? 6'h20 : ((j == 6) ? 6'h01 : ((j == 10) ? 6'h00 : r[29:24])));
      if (r[22]) issue(ACSL_OP_STORE_WORD, {16'h0000, r[15:0]}, 1'b0, 1'b0, 6'h00);
    end
    issue(ACSL_OP_LOAD_ADDRESS_CONVERSION, 32'h0004_0400, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_BIT_FIELD, 32'h0000_0010, 1'b0, 1'b0, 6'h07);
    $display("Test load kinds finished");
    issue(ACSL_OP_LOAD_ADDRESS_CONVERSION, 32'h0000_0025, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_INDEXED_WORD, 32'h0000_0308, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_STORE_WORD, 32'h0000_0340, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_INDEXED_CONSTANT, 32'h0000_0040, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_WORD, 32'h0000_0002, 1'b1, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_INDEXED_CONSTANT, 32'h0000_0040, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_LOAD_INDEXED_WORD, 32'h0000_fff0, 1'b0, 1'b0, 6'h00);
    $display("Test indexed loads finished");
    end_scan();
    for (int j = 0; j < 10; j++) begin
      issue(ACSL_OP_LOAD_DOUBLE_WORD, $urandom, 1'b1, 1'b0, 6'h00);
    end
    for (int j = 0; j < 10; j++) begin
      issue(ACSL_OP_PULL, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
    end
    $display("Test stack depth finished");
    issue(ACSL_OP_LOAD_DOUBLE_WORD, 32'h6705_3101, 1'b1, 1'b0, 6'h00);
    issue(ACSL_OP_AND_DOUBLE, 32'h0ff0_ff0f, 1'b1, 1'b0, 6'h00);
    issue(ACSL_OP_SHIFT_RIGHT, 32'h0000_0000, 1'b0, 1'b0, 6'h04);
    issue(ACSL_OP_LOAD_DOUBLE_WORD, 32'h0000_0123, 1'b0, 1'b1, 6'h00);
    issue(ACSL_OP_AND_DOUBLE, 32'h0000_0123, 1'b0, 1'b0, 6'h00);
    issue(ACSL_OP_STORE_WORD, 32'h0000_0155, 1'b0, 1'b1, 6'h00);
    $display("Test manipulation finished");
    issue(ACSL_OP_LOAD_WORD, 32'h0000_4935, 1'b1, 1'b0, 6'h00);
    end_scan();
    issue(ACSL_OP_LOAD_WORD, 32'h0000_0777, 1'b0, 1'b1, 6'h00);
    issue(ACSL_OP_LOAD_WORD, 32'h0000_0001, 1'b1, 1'b0, 6'h00);
    $display("Test scan end finished");
    repeat (5) @(negedge sys_clk);
    summarize();
  end
endmodule
